// ==== nsoc_top.sv ====
// negative-sequence overcurrent timer with apb settings and interrupt
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module nsoc_top #(
   parameter logic [19:0] NOM_MAG = 20'h003e8,
   parameter int TICK_CYCLES = nsoc_pkg::TICK_CYC
) (
   input wire logic pclk, // apb clock, 40 mhz
   input wire logic presetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic sample_valid, // new phasor set
   input wire nsoc_pkg::nsoc_phasor_s phase_a_phasor, // phase a fundamental
   input wire nsoc_pkg::nsoc_phasor_s phase_b_phasor, // phase b fundamental
   input wire nsoc_pkg::nsoc_phasor_s phase_c_phasor, // phase c fundamental
   input wire logic inhibit_in, // disables the function
   output logic pickup_flag, // started
   output logic operate_flag, // tripped
   output logic combined_pickup, // general start
   output logic combined_operate, // general trip
   output logic irq // level interrupt
);
   typedef enum logic [1:0] {ST_IDLE, ST_RATIO, ST_TIME} nsoc_fsm_e;
   localparam int DW = 48;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [3:0] curve_q;
   logic [9:0] pick_q;
   logic [10:0] tms_q;
   logic [15:0] mind_q, fixd_q, reld_q;
   logic [1:0] ist_q, imsk_q;
   logic [31:0] prdata_q, rd_w;
   logic pready_q, pslverr_q, hit_w, wr_w, irq_q;
   logic start_q, trip_q, cst_q, ctr_q;
   logic [12:0] ratio_q, rc_w;
   logic [19:0] t_op_q, t_rst_q, opc_q, rsc_q, op_tgt_w, rel_tgt_w;
   logic [15:0] tk_q;
   logic tick_q, off_w, inv_w, ansi_w, rpath_q;
   nsoc_fsm_e st_q;
   nsoc_pkg::nsoc_cconst_s cc_w;

   function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo, hi);
      if (v < 32'(lo)) return lo;
      if (v > 32'(hi)) return hi;
      return v[15:0];
   endfunction

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pickup_flag = start_q;
   assign operate_flag = trip_q;
   assign combined_pickup = cst_q;
   assign combined_operate = ctr_q;
   assign irq = irq_q;

   assign off_w = inhibit_in | (curve_q == nsoc_pkg::CV_OFF);
   assign inv_w = curve_q >= nsoc_pkg::CV_IEC_NI;
   assign ansi_w = curve_q >= nsoc_pkg::CV_ANSI_NI;
   assign cc_w = nsoc_pkg::nsoc_curve_tab(curve_q);
   assign wr_w = psel & penable & pready_q & pwrite;

   always_comb begin
      hit_w = 1'b1;
      rd_w = '0;
      case (paddr)
         nsoc_pkg::A_CURVE: rd_w = 32'(curve_q);
         nsoc_pkg::A_PICK: rd_w = 32'(pick_q);
         nsoc_pkg::A_TMS: rd_w = 32'(tms_q);
         nsoc_pkg::A_MIND: rd_w = 32'(mind_q);
         nsoc_pkg::A_FIXD: rd_w = 32'(fixd_q);
         nsoc_pkg::A_RELD: rd_w = 32'(reld_q);
         nsoc_pkg::A_STAT: rd_w = 32'({ctr_q, cst_q, trip_q, start_q});
         nsoc_pkg::A_IST: rd_w = 32'(ist_q);
         nsoc_pkg::A_IMSK: rd_w = 32'(imsk_q);
         nsoc_pkg::A_RATIO: rd_w = 32'(ratio_q);
         default: hit_w = 1'b0;
      endcase
   end

   // answer registered in the setup cycle so the access phase completes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & ~penable;
         if (psel & ~penable) begin
            prdata_q <= pwrite ? '0 : rd_w;
            pslverr_q <= ~hit_w;
         end
      end
   end

   // numeric settings are clamped into their legal range on write; an illegal curve code selects off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         curve_q <= nsoc_pkg::CV_OFF;
         pick_q <= 10'(nsoc_pkg::PICK_RST);
         tms_q <= 11'(nsoc_pkg::TMS_RST);
         mind_q <= nsoc_pkg::DLY_RST;
         fixd_q <= nsoc_pkg::DLY_RST;
         reld_q <= nsoc_pkg::DLY_RST;
         imsk_q <= '0;
      end else if (wr_w) begin
         case (paddr)
            nsoc_pkg::A_CURVE: curve_q <= (pwdata > 32'(nsoc_pkg::CV_ANSI_LEI)) ?
               nsoc_pkg::CV_OFF : pwdata[3:0];
            nsoc_pkg::A_PICK:
               pick_q <= 10'(clamp(pwdata, nsoc_pkg::PICK_MIN, nsoc_pkg::PICK_MAX));
            nsoc_pkg::A_TMS:
               tms_q <= 11'(clamp(pwdata, nsoc_pkg::TMS_MIN, nsoc_pkg::TMS_MAX));
            nsoc_pkg::A_MIND: mind_q <= clamp(pwdata, nsoc_pkg::DLY_MIN, nsoc_pkg::DLY_MAX);
            nsoc_pkg::A_FIXD: fixd_q <= clamp(pwdata, nsoc_pkg::DLY_MIN, nsoc_pkg::DLY_MAX);
            nsoc_pkg::A_RELD: reld_q <= clamp(pwdata, nsoc_pkg::REL_MIN, nsoc_pkg::DLY_MAX);
            nsoc_pkg::A_IMSK: imsk_q <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // sticky events; a new event wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~((wr_w && paddr == nsoc_pkg::A_IST) ? pwdata[1:0] : 2'h0))
            | {trip_q & ~ctr_q, start_q & ~cst_q};
         irq_q <= |(ist_q & imsk_q);
      end
   end

   // negative sequence: (a + a^2 b + a c) / 3
   logic signed [19:0] xr, xi, sr, si;
   logic signed [35:0] pr, pi;
   logic [18:0] abr, abi, mx, mn;
   logic [19:0] mag_w;
   always_comb begin
      xr = 20'(phase_a_phasor.re) - ((20'(phase_b_phasor.re) + 20'(phase_c_phasor.re)) >>> 1)
         + 20'(((27'(phase_b_phasor.im) - 27'(phase_c_phasor.im)) * nsoc_pkg::SQ3_Q10)
         >>> nsoc_pkg::Q10);
      xi = 20'(phase_a_phasor.im) - ((20'(phase_b_phasor.im) + 20'(phase_c_phasor.im)) >>> 1)
         + 20'(((27'(phase_c_phasor.re) - 27'(phase_b_phasor.re)) * nsoc_pkg::SQ3_Q10)
         >>> nsoc_pkg::Q10);
      pr = 36'(xr) * nsoc_pkg::THIRD_Q16;
      pi = 36'(xi) * nsoc_pkg::THIRD_Q16;
      sr = 20'(pr >>> nsoc_pkg::Q16);
      si = 20'(pi >>> nsoc_pkg::Q16);
      abr = sr[19] ? 19'(-sr) : 19'(sr);
      abi = si[19] ? 19'(-si) : 19'(si);
      mx = (abr > abi) ? abr : abi;
      mn = (abr > abi) ? abi : abr;
      // max plus 3/8 min: within about 7 percent of the true magnitude, no root needed
      mag_w = 20'(mx) + 20'((22'(mn) * 22'(nsoc_pkg::BETA_N)) >> nsoc_pkg::BETA_SH);
   end

   // shared restoring divider, one quotient bit per clock
   logic [DW-1:0] dq_q, go_n;
   logic [31:0] dr_q, dd_q, go_d;
   logic [5:0] dc_q;
   logic [33:0] trial;
   logic div_go;
   assign trial = {1'b0, dr_q, dq_q[DW-1]} - {2'h0, dd_q};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_q <= '0;
         dr_q <= '0;
         dd_q <= '0;
         dc_q <= '0;
      end else if (div_go) begin
         dq_q <= go_n;
         dr_q <= '0;
         dd_q <= go_d;
         dc_q <= 6'(DW);
      end else if (dc_q != 6'h0) begin
         dr_q <= trial[33] ? {dr_q[30:0], dq_q[DW-1]} : trial[31:0];
         dq_q <= {dq_q[DW-2:0], ~trial[33]};
         dc_q <= dc_q - 6'h1;
      end
   end

   // ratio clamp, curve denominators and time scaling
   logic [25:0] m2_w;
   logic [3:0] lp_w;
   logic [19:0] lg_w;
   logic [31:0] den_w;
   logic [24:0] tq_w;
   logic [35:0] prod_w;
   logic [52:0] tms_w;
   logic [19:0] tres_w;
   always_comb begin
      rc_w = (dq_q > DW'(nsoc_pkg::RMAX_Q8)) ? nsoc_pkg::RMAX_Q8 : dq_q[12:0];
      m2_w = 26'(rc_w) * 26'(rc_w);
      lp_w = 4'h0;
      for (int i = 0; i < 13; i++) begin
         if (rc_w[i]) lp_w = 4'(i);
      end
      // linear log2 in q16: integer part from the leading one, mantissa as fraction
      lg_w = {4'(lp_w - 4'(nsoc_pkg::Q8)), 16'(rc_w << (5'd16 - 5'(lp_w)))};
      case (cc_w.al)
         nsoc_pkg::AL_2: den_w = 32'(m2_w) - nsoc_pkg::ONE_Q16;
         nsoc_pkg::AL_1: den_w = 32'({rc_w, 8'h0}) - nsoc_pkg::ONE_Q16;
         default: den_w = 32'((30'(lg_w) * 30'(nsoc_pkg::LN2_A)) >> nsoc_pkg::Q16);
      endcase
      tq_w = (|dq_q[DW-1:24]) ? '1 : 25'(dq_q[23:0]);
      prod_w = 36'(tq_w + (rpath_q ? 25'h0 : 25'(cc_w.c))) * 36'(tms_q);
      tms_w = (53'(prod_w) * 53'(nsoc_pkg::SCL_NUM)) >> nsoc_pkg::SCL_SH;
      tres_w = (|tms_w[52:20]) ? nsoc_pkg::T_SAT : tms_w[19:0];
   end

   // per-sample evaluation: ratio, then operate or reset time
   always_comb begin
      div_go = 1'b0;
      go_n = '0;
      go_d = '0;
      if (st_q == ST_IDLE && sample_valid && !off_w) begin
         div_go = 1'b1;
         go_n = DW'(mag_w) * DW'(nsoc_pkg::PCT_Q8);
         go_d = 32'(pick_q) * 32'(NOM_MAG);
      end else if (st_q == ST_RATIO && dc_q == 6'h0 && inv_w) begin
         if (rc_w > nsoc_pkg::ONE_Q8) begin
            div_go = 1'b1;
            go_n = DW'(cc_w.k) << nsoc_pkg::Q16;
            go_d = den_w;
         end else if (ansi_w && rc_w < nsoc_pkg::ONE_Q8) begin
            div_go = 1'b1;
            go_n = DW'(cc_w.kr) << nsoc_pkg::Q16;
            go_d = nsoc_pkg::ONE_Q16 - 32'(m2_w);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         rpath_q <= 1'b0;
         ratio_q <= '0;
         t_op_q <= nsoc_pkg::T_SAT;
         t_rst_q <= nsoc_pkg::T_SAT;
      end else if (off_w) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: if (div_go) st_q <= ST_RATIO;
            ST_RATIO: if (dc_q == 6'h0) begin
               ratio_q <= rc_w;
               rpath_q <= rc_w < nsoc_pkg::ONE_Q8;
               st_q <= div_go ? ST_TIME : ST_IDLE;
            end
            ST_TIME: if (dc_q == 6'h0) begin
               if (rpath_q) t_rst_q <= tres_w;
               else t_op_q <= tres_w;
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // pickup with hysteresis, evaluated once per sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
      end else if (off_w) begin
         start_q <= 1'b0;
      end else if (st_q == ST_RATIO && dc_q == 6'h0) begin
         if (rc_w > nsoc_pkg::ONE_Q8) start_q <= 1'b1;
         else if (rc_w < nsoc_pkg::DROP_Q8) start_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tk_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= tk_q == 16'(TICK_CYCLES - 1);
         tk_q <= (tk_q == 16'(TICK_CYCLES - 1)) ? 16'h0 : tk_q + 16'h1;
      end
   end

   // the minimum delay floors a short inverse time; definite time ignores the curve
   assign op_tgt_w = (curve_q == nsoc_pkg::CV_DEF) ? 20'(fixd_q) :
      ((t_op_q < 20'(mind_q)) ? 20'(mind_q) : t_op_q);
   assign rel_tgt_w = ansi_w ? t_rst_q : 20'(reld_q);

   // operate timer in ms; below pickup an inverse curve keeps its count until release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opc_q <= '0;
         rsc_q <= '0;
      end else if (off_w) begin
         opc_q <= '0;
         rsc_q <= '0;
      end else if (tick_q) begin
         if (start_q) begin
            opc_q <= (opc_q == nsoc_pkg::T_SAT) ? opc_q : opc_q + 20'h1;
            rsc_q <= '0;
         end else if (!inv_w) begin
            opc_q <= '0;
         end else if (rsc_q >= rel_tgt_w) begin
            opc_q <= '0;
         end else if (opc_q != 20'h0) begin
            rsc_q <= rsc_q + 20'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_q <= 1'b0;
         cst_q <= 1'b0;
         ctr_q <= 1'b0;
      end else begin
         trip_q <= !off_w && start_q && opc_q >= op_tgt_w;
         cst_q <= !off_w && start_q;
         ctr_q <= !off_w && trip_q;
      end
   end

   a_inhibit_clears: assert property (inhibit_in |=> !pickup_flag && !operate_flag
      && !combined_operate) else $error("flags not cleared under inhibit");
   a_off_timers: assert property (off_w |=> opc_q == 20'h0 && rsc_q == 20'h0)
      else $error("timers not cleared while off");
   a_general_start: assert property (!off_w ##1 !off_w |-> combined_pickup == $past(start_q))
      else $error("combined pickup does not follow pickup");
   a_trip_cause: assert property ($rose(operate_flag) |-> $past(start_q)
      && $past(opc_q) >= $past(op_tgt_w)) else $error("operate without elapsed delay");
   a_ratio_held: assert property (ratio_q <= nsoc_pkg::RMAX_Q8)
      else $error("ratio above twenty");
   a_start_above: assert property ($rose(pickup_flag) |-> ratio_q > nsoc_pkg::ONE_Q8)
      else $error("pickup without overcurrent");
   a_start_hyst: assert property ($fell(pickup_flag) |-> $past(off_w)
      || ratio_q < nsoc_pkg::DROP_Q8) else $error("pickup dropped above reset ratio");
   a_min_floor: assert property (inv_w |-> op_tgt_w >= 20'(mind_q))
      else $error("inverse delay below minimum");
   a_def_delay: assert property (curve_q == nsoc_pkg::CV_DEF |-> op_tgt_w == 20'(fixd_q))
      else $error("definite delay not used");
   a_pick_range: assert property (pick_q >= 10'(nsoc_pkg::PICK_MIN)
      && pick_q <= 10'(nsoc_pkg::PICK_MAX)) else $error("pickup level out of range");
   a_tms_range: assert property (tms_q >= 11'(nsoc_pkg::TMS_MIN)
      && tms_q <= 11'(nsoc_pkg::TMS_MAX)) else $error("time scale out of range");
   a_rel_range: assert property (reld_q >= nsoc_pkg::REL_MIN)
      else $error("release delay below minimum");
   a_curve_legal: assert property (curve_q <= nsoc_pkg::CV_ANSI_LEI)
      else $error("illegal curve code");
endmodule

// ==== nsoc_pkg.sv ====
// package: constants, types and curve table of the negative-sequence overcurrent timer
package nsoc_pkg;
   typedef struct packed {
      logic signed [15:0] re;
      logic signed [15:0] im;
   } nsoc_phasor_s;

   typedef enum logic [3:0] {
      CV_OFF, CV_DEF, CV_IEC_NI, CV_IEC_VI, CV_IEC_EI, CV_IEC_LI, CV_ANSI_NI, CV_ANSI_MI,
      CV_ANSI_VI, CV_ANSI_EI, CV_ANSI_LI, CV_ANSI_LVI, CV_ANSI_LEI
   } nsoc_curve_e;

   typedef enum logic [1:0] {AL_002, AL_1, AL_2} nsoc_alpha_e;

   // k and c in 0.1 ms units, kr in 0.1 ms units
   typedef struct packed {
      logic [20:0] k;
      logic [12:0] c;
      logic [18:0] kr;
      nsoc_alpha_e al;
   } nsoc_cconst_s;

   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_PER_S = 1000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;

   localparam logic [7:0] A_CURVE = 8'h00;
   localparam logic [7:0] A_PICK = 8'h04;
   localparam logic [7:0] A_TMS = 8'h08;
   localparam logic [7:0] A_MIND = 8'h0c;
   localparam logic [7:0] A_FIXD = 8'h10;
   localparam logic [7:0] A_RELD = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_IST = 8'h1c;
   localparam logic [7:0] A_IMSK = 8'h20;
   localparam logic [7:0] A_RATIO = 8'h24;

   localparam logic [15:0] PICK_RST = 16'h0032;
   localparam logic [15:0] PICK_MIN = 16'h000a;
   localparam logic [15:0] PICK_MAX = 16'h03e8;
   localparam logic [15:0] TMS_RST = 16'h0064;
   localparam logic [15:0] TMS_MIN = 16'h0005;
   localparam logic [15:0] TMS_MAX = 16'h05dc;
   localparam logic [15:0] DLY_RST = 16'h0064;
   localparam logic [15:0] DLY_MIN = 16'h0028;
   localparam logic [15:0] DLY_MAX = 16'hea60;
   localparam logic [15:0] REL_MIN = 16'h003c;

   localparam logic [12:0] ONE_Q8 = 13'h0100;
   localparam logic [12:0] DROP_Q8 = 13'h00f3;
   localparam logic [12:0] RMAX_Q8 = 13'h1400;
   localparam logic [31:0] ONE_Q16 = 32'h0001_0000;
   localparam logic [15:0] PCT_Q8 = 16'h6400;
   localparam logic signed [26:0] SQ3_Q10 = 27'sh377;
   localparam logic signed [35:0] THIRD_Q16 = 36'sh5555;
   localparam logic [9:0] LN2_A = 10'h38c;
   localparam logic [16:0] SCL_NUM = 17'h10625;
   localparam int Q8 = 8;
   localparam int Q10 = 10;
   localparam int Q16 = 16;
   localparam int SCL_SH = 26;
   localparam logic [1:0] BETA_N = 2'h3;
   localparam int BETA_SH = 3;
   localparam logic [19:0] T_SAT = 20'hfffff;

   function automatic nsoc_cconst_s nsoc_curve_tab(input logic [3:0] cv);
      nsoc_cconst_s r;
      r = '0;
      case (cv)
         CV_IEC_NI: r = '{21'h000578, 13'h0000, 19'h00000, AL_002};
         CV_IEC_VI: r = '{21'h020f58, 13'h0000, 19'h00000, AL_1};
         CV_IEC_EI: r = '{21'h0c3500, 13'h0000, 19'h00000, AL_2};
         CV_IEC_LI: r = '{21'h124f80, 13'h0000, 19'h00000, AL_1};
         CV_ANSI_NI: r = '{21'h000056, 13'h00b9, 19'h011f8, AL_002};
         CV_ANSI_MI: r = '{21'h000203, 13'h0474, 19'h0bd74, AL_002};
         CV_ANSI_VI: r = '{21'h02fe04, 13'h132e, 19'h34bc0, AL_2};
         CV_ANSI_EI: r = '{21'h044d90, 13'h04c1, 19'h470b8, AL_2};
         CV_ANSI_LI: r = '{21'h00035c, 13'h073a, 19'h0b3b0, AL_002};
         CV_ANSI_LVI: r = '{21'h045b3c, 13'h1bd0, 19'h20dc8, AL_2};
         CV_ANSI_LEI: r = '{21'h09c6bc, 13'h09c4, 19'h493e0, AL_2};
         default: r = '0;
      endcase
      return r;
   endfunction
endpackage

// ==== nsoc_phasor_src.sv ====
// phasor preprocessing and blocking logic model driving the overcurrent timer
`timescale 1ns/100ps
module nsoc_phasor_src (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic run, // send samples
   input wire logic [15:0] amp, // phase a real part
   input wire logic block_req, // user blocking request
   output logic sample_valid, // sample strobe
   output nsoc_pkg::nsoc_phasor_s pa, // phase a phasor
   output nsoc_pkg::nsoc_phasor_s pb, // phase b phasor
   output nsoc_pkg::nsoc_phasor_s pc, // phase c phasor
   output logic inhibit_in // disable level
);
   logic [7:0] gap_q;
   logic fire;
   // spacing above the evaluation time so no sample is dropped as busy
   assign fire = run && (gap_q == 8'h77);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 8'h00;
         sample_valid <= 1'b0;
         pa <= '0;
         pb <= '0;
         pc <= '0;
      end else begin
         gap_q <= fire || gap_q == 8'h77 ? 8'h00 : gap_q + 8'h01;
         sample_valid <= fire;
         if (fire) begin
            pa <= '{re: amp, im: 16'sh0000};
            pb <= '0;
            pc <= '0;
         end else begin
            // phasor lines are not valid between strobes, so they toggle
            pa <= nsoc_pkg::nsoc_phasor_s'(~pa);
            pb <= nsoc_pkg::nsoc_phasor_s'(~pb);
            pc <= nsoc_pkg::nsoc_phasor_s'(~pc);
         end
      end
   end
   assign inhibit_in = block_req;
endmodule

// ==== nsoc_top_bench.sv ====
// self-checking bench for the negative-sequence overcurrent timer
`timescale 1ns/100ps
module nsoc_top_bench;
   localparam int TK = 40; // one timer ms in clocks, keeps runs short
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, inhibit_in;
   logic pickup_flag, operate_flag, combined_pickup, combined_operate, irq, run, block_req, err;
   logic [7:0] paddr;
   logic [15:0] amp;
   logic [31:0] pwdata, prdata, rdv;
   nsoc_pkg::nsoc_phasor_s pa, pb, pc;
   int num_errors, cmp_count, cyc, tmo, x, r, t;
   logic [7:0] ra[8] = '{nsoc_pkg::A_CURVE, nsoc_pkg::A_PICK, nsoc_pkg::A_TMS, nsoc_pkg::A_MIND,
      nsoc_pkg::A_FIXD, nsoc_pkg::A_RELD, nsoc_pkg::A_IMSK, nsoc_pkg::A_CURVE};
   logic [31:0] rv[8] = '{0, nsoc_pkg::PICK_RST, nsoc_pkg::TMS_RST, nsoc_pkg::DLY_RST,
      nsoc_pkg::DLY_RST, nsoc_pkg::DLY_RST, 0, 0};
   logic [31:0] cw[8] = '{13, 5, 2000, 1, 10, 61000, 10, 2000};
   logic [31:0] ce[8] = '{0, nsoc_pkg::PICK_MIN, nsoc_pkg::TMS_MAX, nsoc_pkg::TMS_MIN,
      nsoc_pkg::DLY_MIN, nsoc_pkg::DLY_MAX, nsoc_pkg::REL_MIN, nsoc_pkg::PICK_MAX};
   logic [7:0] ca[8] = '{nsoc_pkg::A_CURVE, nsoc_pkg::A_PICK, nsoc_pkg::A_TMS, nsoc_pkg::A_TMS,
      nsoc_pkg::A_MIND, nsoc_pkg::A_FIXD, nsoc_pkg::A_RELD, nsoc_pkg::A_PICK};

   nsoc_top #(.TICK_CYCLES(TK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .phase_a_phasor(pa),
      .phase_b_phasor(pb), .phase_c_phasor(pc), .inhibit_in(inhibit_in),
      .pickup_flag(pickup_flag), .operate_flag(operate_flag), .combined_pickup(combined_pickup),
      .combined_operate(combined_operate), .irq(irq));
   nsoc_phasor_src src (.pclk(pclk), .presetn(presetn), .run(run), .amp(amp),
      .block_req(block_req), .sample_valid(sample_valid), .pa(pa), .pb(pb), .pc(pc),
      .inhibit_in(inhibit_in));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
      cmp_count++;
      if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
         num_errors++;
         $display("mismatch at %0t: %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(0, 1, "apb answer");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp, "register read");
   endtask
   task automatic drive(input int v);
      amp <= 16'(v);
      run <= 1'b1;
   endtask
   task automatic wait_for(input int which, input logic val, input int lim);
      cyc = 0;
      while (cyc < lim && (which == 0 ? pickup_flag : operate_flag) !== val) begin
         @(posedge pclk);
         cyc++;
      end
      if (cyc >= lim) chk(!val, val, "flag wait");
   endtask
   function automatic int exp_ratio(input int v, input int pick);
      int q;
      q = (v / 3) * 256 / (pick * 10);
      return q > 5120 ? 5120 : q;
   endfunction
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge pclk) begin
      tmo++;
      if (tmo == 30000) begin
         num_errors++;
         $display("mismatch at %0t: run too long", $time);
         end_sim();
      end
   end

   initial begin
      num_errors = 0;
      cmp_count = 0;
      tmo = 0;
      {presetn, psel, penable, pwrite, run, block_req} = '0;
      paddr = '0;
      pwdata = '0;
      amp = '0;
      void'($urandom(32'hf06e015a));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      apb(1'b0, 8'h28, 32'h0);
      chk(err, 1, "unmapped error");
      chk(rdv, 0, "unmapped data");
      $display("test reset values done");
      foreach (ca[i]) begin
         apb(1'b1, ca[i], cw[i]);
         rd(ca[i], ce[i]);
      end
      $display("test setting limits done");
      apb(1'b1, nsoc_pkg::A_PICK, 100);
      apb(1'b1, nsoc_pkg::A_FIXD, 40);
      apb(1'b1, nsoc_pkg::A_IMSK, 3);
      apb(1'b1, nsoc_pkg::A_CURVE, 1);
      drive(6000);
      wait_for(0, 1'b1, 400);
      wait_for(1, 1'b1, 45 * TK);
      chk_rng(cyc, 38 * TK, 42 * TK, "definite delay");
      repeat (2) @(posedge pclk);
      chk({combined_operate, combined_pickup, irq}, 3'h7, "merged outputs");
      rd(nsoc_pkg::A_STAT, 32'hf);
      apb(1'b0, nsoc_pkg::A_RATIO, 32'h0);
      chk_rng(rdv, exp_ratio(6000, 100) - 2, exp_ratio(6000, 100) + 2, "ratio");
      apb(1'b1, nsoc_pkg::A_IMSK, 0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "masked irq");
      apb(1'b1, nsoc_pkg::A_IST, 3);
      apb(1'b1, nsoc_pkg::A_IMSK, 3);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "cleared irq");
      $display("test definite time done");
      drive(2910);
      repeat (300) @(posedge pclk);
      chk(pickup_flag, 1'b1, "hysteresis hold");
      drive(2700);
      wait_for(0, 1'b0, 400);
      repeat (2) @(posedge pclk);
      chk(operate_flag, 1'b0, "operate drop");
      $display("test hysteresis done");
      drive(6000);
      wait_for(0, 1'b1, 400);
      block_req <= 1'b1;
      repeat (300) @(posedge pclk);
      chk({combined_pickup, pickup_flag, operate_flag}, 3'h0, "inhibited");
      block_req <= 1'b0;
      wait_for(0, 1'b1, 400);
      apb(1'b1, nsoc_pkg::A_CURVE, 0);
      repeat (3) @(posedge pclk);
      chk({combined_pickup, pickup_flag}, 2'h0, "curve off");
      $display("test disable done");
      apb(1'b1, nsoc_pkg::A_PICK, 10);
      apb(1'b1, nsoc_pkg::A_TMS, 5);
      apb(1'b1, nsoc_pkg::A_MIND, 40);
      apb(1'b1, nsoc_pkg::A_CURVE, 3);
      drive(9000);
      wait_for(0, 1'b1, 400);
      wait_for(1, 1'b1, 50 * TK);
      chk_rng(cyc, 38 * TK, 43 * TK, "minimum delay");
      apb(1'b0, nsoc_pkg::A_RATIO, 32'h0);
      chk(rdv, 5120, "ratio ceiling");
      $display("test inverse minimum done");
      apb(1'b1, nsoc_pkg::A_CURVE, 0);
      apb(1'b1, nsoc_pkg::A_PICK, 100);
      drive(30000);
      apb(1'b1, nsoc_pkg::A_CURVE, 3);
      t = 5 * 135000 * 256 / (1000 * (exp_ratio(30000, 100) - 256));
      wait_for(0, 1'b1, 400);
      wait_for(1, 1'b1, (t + 10) * TK);
      chk_rng(cyc, (t - 2) * TK, (t + 2) * TK, "inverse time");
      drive(2700);
      wait_for(0, 1'b0, 400);
      repeat (30 * TK) @(posedge pclk);
      drive(30000);
      wait_for(0, 1'b1, 400);
      wait_for(1, 1'b1, 5 * TK);
      chk_rng(cyc, 0, 2, "held count");
      drive(2700);
      wait_for(0, 1'b0, 400);
      repeat (70 * TK) @(posedge pclk);
      drive(30000);
      wait_for(0, 1'b1, 400);
      wait_for(1, 1'b1, (t + 10) * TK);
      chk_rng(cyc, (t - 2) * TK, (t + 2) * TK, "released count");
      $display("test inverse time done");
      for (int c = 2; c <= 12; c++) begin
         apb(1'b1, nsoc_pkg::A_CURVE, 0);
         x = 3300 + $urandom_range(26000);
         r = exp_ratio(x, 100);
         drive(x);
         apb(1'b1, nsoc_pkg::A_CURVE, c);
         wait_for(0, 1'b1, 400);
         apb(1'b0, nsoc_pkg::A_RATIO, 32'h0);
         chk_rng(rdv, r - 2, r + 2, "curve ratio");
      end
      $display("test all curves done");
      end_sim();
   end
endmodule
